/* File: rtl/slp_mdio_slave.sv */
`timescale 1ns/10ps
module slp_mdio_slave #(
  parameter logic [4:0] PHY_ADDR = slp_pkg::PHY_ADDR_DEF
) (
  input wire logic core_clk_i, // System clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic mdc_i, // Management clock pin
  input wire logic mdio_i, // Management data pin level
  input wire logic [15:0] rd_data_i, // Read data for reg_addr_o
  output logic mdio_oe_o, // Pull data pin low
  output logic [4:0] reg_addr_o, // Addressed register
  output logic [15:0] wr_data_o, // Write data
  output logic wr_stb_o, // Write pulse
  output logic rd_stb_o // Read pulse, data captured same edge
);
  typedef enum logic [2:0] {S_PRE, S_ST, S_HDR, S_LOAD, S_TA, S_DATA} slp_mdio_st_e;

  logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
  slp_mdio_st_e st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic rd_r, rd_nxt, oe_nxt, wr_stb_nxt, rd_stb_nxt;
  logic [4:0] addr_nxt;
  logic [15:0] wd_nxt;
  logic mdc_rise;

  // Pin synchronisers; the edge detector reads only second and third stages
  always_ff @(posedge core_clk_i) begin
    mdc_s1 <= mdc_i;
    mdc_s2 <= mdc_s1;
    mdc_s3 <= mdc_s2;
    mdio_s1 <= mdio_i;
    mdio_s2 <= mdio_s1;
  end

  assign mdc_rise = mdc_s2 & ~mdc_s3;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    rd_nxt = rd_r;
    oe_nxt = mdio_oe_o;
    addr_nxt = reg_addr_o;
    wd_nxt = wr_data_o;
    wr_stb_nxt = 1'b0;
    rd_stb_nxt = 1'b0;
    if (st_r == S_LOAD) begin
      // Capture on the edge that clears the pending bits, so no event slips between
      sh_nxt = rd_data_i;
      st_nxt = S_TA;
    end else if (mdc_rise) begin
      unique case (st_r)
        S_PRE: begin
          if (mdio_s2) begin
            cnt_nxt = (cnt_r == 6'(slp_pkg::PRE_LEN)) ? cnt_r : cnt_r + 6'd1;
          end else if (cnt_r == 6'(slp_pkg::PRE_LEN)) begin
            st_nxt = S_ST;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = '0;
          end
        end
        S_ST: begin
          st_nxt = mdio_s2 ? S_HDR : S_PRE;
          cnt_nxt = '0;
        end
        S_HDR: begin
          sh_nxt = {sh_r[14:0], mdio_s2};
          cnt_nxt = cnt_r + 6'd1;
          if (cnt_r == 6'(slp_pkg::HDR_BITS - 1)) begin
            cnt_nxt = '0;
            st_nxt = S_PRE;
            if (sh_nxt[9:5] == PHY_ADDR &&
                (sh_nxt[11:10] == slp_pkg::OP_RD || sh_nxt[11:10] == slp_pkg::OP_WR)) begin
              addr_nxt = sh_nxt[4:0];
              rd_nxt = (sh_nxt[11:10] == slp_pkg::OP_RD);
              rd_stb_nxt = rd_nxt;
              st_nxt = rd_nxt ? S_LOAD : S_TA;
            end
          end
        end
        S_LOAD: begin
        end
        S_TA: begin
          cnt_nxt = cnt_r + 6'd1;
          if (cnt_r == '0) begin
            oe_nxt = rd_r;
          end else begin
            st_nxt = S_DATA;
            cnt_nxt = '0;
            if (rd_r) begin
              oe_nxt = ~sh_r[15];
              sh_nxt = {sh_r[14:0], 1'b0};
            end
          end
        end
        S_DATA: begin
          cnt_nxt = cnt_r + 6'd1;
          if (rd_r) begin
            oe_nxt = ~sh_r[15];
            sh_nxt = {sh_r[14:0], 1'b0};
          end else begin
            sh_nxt = {sh_r[14:0], mdio_s2};
          end
          if (cnt_r == 6'(slp_pkg::DATA_BITS - 1)) begin
            st_nxt = S_PRE;
            cnt_nxt = '0;
            oe_nxt = 1'b0;
            if (!rd_r) begin
              wr_stb_nxt = 1'b1;
              wd_nxt = sh_nxt;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= S_PRE;
      cnt_r <= '0;
      sh_r <= '0;
      rd_r <= 1'b0;
      mdio_oe_o <= 1'b0;
      reg_addr_o <= '0;
      wr_data_o <= '0;
      wr_stb_o <= 1'b0;
      rd_stb_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      rd_r <= rd_nxt;
      mdio_oe_o <= oe_nxt;
      reg_addr_o <= addr_nxt;
      wr_data_o <= wd_nxt;
      wr_stb_o <= wr_stb_nxt;
      rd_stb_o <= rd_stb_nxt;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence last_data_s;
    st_r == S_DATA && mdc_rise && cnt_r == 6'(slp_pkg::DATA_BITS - 1);
  endsequence

  data_release_a: assert property (last_data_s |=> !mdio_oe_o && st_r == S_PRE)
    else $error("data pin not released after last data bit");
  write_strobe_a: assert property (last_data_s and !rd_r |=> wr_stb_o ##1 !wr_stb_o)
    else $error("write strobe missing or not one cycle");
  read_strobe_a: assert property (rd_stb_o == (st_r == S_LOAD))
    else $error("read strobe not aligned with data capture");
endmodule // slp_mdio_slave

/* File: rtl/slp_pkg.sv */
package slp_pkg;
  // Management register map
  localparam logic [4:0] REG_IRQ_CS = 5'h1b;
  localparam logic [4:0] REG_CTRL_TWO = 5'h1f;
  // Control-two field and reset value; polarity bit low means active-low output
  localparam int CTRL2_IRQ_POL = 9;
  localparam logic [15:0] CTRL2_RST = 16'h0000;
  // Interrupt control/status layout: enables high byte, pending low byte
  localparam int IRQ_W = 8;
  localparam int IRQ_EN_LSB = 8;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] IRQ_ST_RST = 8'h00;
  // Management frame
  localparam int PRE_LEN = 32;
  localparam int HDR_BITS = 12;
  localparam int DATA_BITS = 16;
  localparam logic [1:0] OP_RD = 2'b10;
  localparam logic [1:0] OP_WR = 2'b01;
  localparam logic [4:0] PHY_ADDR_DEF = 5'h01;
  // Strap vector positions
  localparam int STRAP_DV = 0;
  localparam int STRAP_CLK = 1;
  localparam int STRAP_ER = 2;
  localparam int STRAP_IRQ = 3;
  localparam int STRAP_W = 4;
endpackage

/* File: rtl/slp_strap_irq.sv */
`timescale 1ns/10ps
module slp_strap_irq #(
  parameter logic [4:0] PHY_ADDR = slp_pkg::PHY_ADDR_DEF
) (
  input wire logic core_clk_i, // System clock, 100 MHz
  input wire logic resetn_i, // Async reset, active low
  input wire logic mdc_i, // Management clock pin
  input wire logic mdio_i, // Management data pin level
  output logic mdio_o, // Management data drive value, always low
  output logic mdio_oe_o, // Management data pull-low enable
  input wire logic rx_dv_pin_i, // Receive-valid pin level
  input wire logic rx_clk_pin_i, // Receive-clock pin level
  input wire logic rx_er_pin_i, // Receive-error pin level
  input wire logic irq_out_pin_i, // Interrupt pin level
  input wire logic mii_rx_dv_i, // Receive valid from data path
  input wire logic mii_rx_clk_i, // Receive clock from data path
  input wire logic mii_rx_er_i, // Receive error from data path
  input wire logic [slp_pkg::IRQ_W-1:0] irq_events_i, // Interrupt event pulses
  input wire logic wake_opt2_sel_i, // Pin serves as wake output
  input wire logic wake_event_i, // Wake event pending, level
  output logic rx_dv_o, // Receive-valid pin value
  output logic rx_dv_oe_o, // Receive-valid pin enable
  output logic rx_clk_o, // Receive-clock pin value
  output logic rx_clk_oe_o, // Receive-clock pin enable
  output logic rx_er_o, // Receive-error pin value
  output logic rx_er_oe_o, // Receive-error pin enable
  output logic irq_out_o, // Interrupt pin value, always low
  output logic irq_out_oe_o, // Interrupt pin pull-low enable
  output logic cfg_strap_bit2_o, // Latched config strap bit 2
  output logic bcast_addr_disable_o, // Latched broadcast disable
  output logic isolate_o, // Latched isolate
  output logic chain_test_n_o // Latched pin-chain test select, active low
);
  logic [slp_pkg::STRAP_W-1:0] pin_s1, pin_s2, straps_r, straps_nxt;
  logic strap_done_r;
  logic [15:0] ctrl2_r, ctrl2_nxt, rd_data;
  logic [slp_pkg::IRQ_W-1:0] en_r, en_nxt, st_r, st_nxt;
  logic [4:0] reg_addr;
  logic [15:0] wr_data;
  logic wr_stb, rd_stb, rd_clr, irq_act, pol_high, wake_event_n_opt2, irq_oe_nxt;
  logic od_zero_r;
  logic [2:0] rx_nxt;
  logic rx_oe_nxt;

  slp_mdio_slave #(.PHY_ADDR(PHY_ADDR)) u_mdio (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .mdc_i(mdc_i),
    .mdio_i(mdio_i),
    .rd_data_i(rd_data),
    .mdio_oe_o(mdio_oe_o),
    .reg_addr_o(reg_addr),
    .wr_data_o(wr_data),
    .wr_stb_o(wr_stb),
    .rd_stb_o(rd_stb)
  );

  // Pins are free-running into the synchroniser, so it holds the pulled
  // levels by the time reset lets go
  always_ff @(posedge core_clk_i) begin
    pin_s1 <= {irq_out_pin_i, rx_er_pin_i, rx_clk_pin_i, rx_dv_pin_i};
    pin_s2 <= pin_s1;
  end

  always_comb begin
    straps_nxt = strap_done_r ? straps_r : pin_s2;
    ctrl2_nxt = (wr_stb && reg_addr == slp_pkg::REG_CTRL_TWO) ? wr_data : ctrl2_r;
    en_nxt = (wr_stb && reg_addr == slp_pkg::REG_IRQ_CS) ?
             wr_data[slp_pkg::IRQ_EN_LSB +: slp_pkg::IRQ_W] : en_r;
    // Pending bits clear on read; a new event in that cycle still sets
    rd_clr = rd_stb && reg_addr == slp_pkg::REG_IRQ_CS;
    st_nxt = (st_r & ~{slp_pkg::IRQ_W{rd_clr}}) | irq_events_i;
    irq_act = |(st_r & en_r);
    pol_high = ctrl2_r[slp_pkg::CTRL2_IRQ_POL];
    wake_event_n_opt2 = ~wake_event_i;
    rx_nxt = {mii_rx_er_i, mii_rx_clk_i, mii_rx_dv_i};
    // Pins stay released until the straps are latched, or a strap would read our own drive
    rx_oe_nxt = strap_done_r;
    // Open drain cannot drive high: active-high means pull low while idle
    if (!strap_done_r) begin
      irq_oe_nxt = 1'b0;
    end else if (wake_opt2_sel_i) begin
      irq_oe_nxt = ~wake_event_n_opt2;
    end else begin
      irq_oe_nxt = pol_high ? ~irq_act : irq_act;
    end
    unique case (reg_addr)
      slp_pkg::REG_IRQ_CS: rd_data = {en_r, st_r};
      slp_pkg::REG_CTRL_TWO: rd_data = ctrl2_r;
      default: rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_done_r <= 1'b0;
      straps_r <= '0;
      ctrl2_r <= slp_pkg::CTRL2_RST;
      en_r <= slp_pkg::IRQ_EN_RST;
      st_r <= slp_pkg::IRQ_ST_RST;
      rx_dv_o <= 1'b0;
      rx_clk_o <= 1'b0;
      rx_er_o <= 1'b0;
      rx_dv_oe_o <= 1'b0;
      rx_clk_oe_o <= 1'b0;
      rx_er_oe_o <= 1'b0;
      irq_out_oe_o <= 1'b0;
      od_zero_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
      straps_r <= straps_nxt;
      ctrl2_r <= ctrl2_nxt;
      en_r <= en_nxt;
      st_r <= st_nxt;
      rx_dv_o <= rx_nxt[0];
      rx_clk_o <= rx_nxt[1];
      rx_er_o <= rx_nxt[2];
      rx_dv_oe_o <= rx_oe_nxt;
      rx_clk_oe_o <= rx_oe_nxt;
      rx_er_oe_o <= rx_oe_nxt;
      irq_out_oe_o <= irq_oe_nxt;
      od_zero_r <= 1'b0;
    end
  end

  assign irq_out_o = od_zero_r;
  assign mdio_o = od_zero_r;
  assign cfg_strap_bit2_o = straps_r[slp_pkg::STRAP_DV];
  assign bcast_addr_disable_o = straps_r[slp_pkg::STRAP_CLK];
  assign isolate_o = straps_r[slp_pkg::STRAP_ER];
  assign chain_test_n_o = straps_r[slp_pkg::STRAP_IRQ];

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence irq_read_s;
    rd_stb && reg_addr == slp_pkg::REG_IRQ_CS && irq_events_i == '0;
  endsequence

  strap_cfg2_a: assert property ($rose(strap_done_r) |->
    cfg_strap_bit2_o == $past(pin_s2[slp_pkg::STRAP_DV])) else $error("strap bit2 wrong");
  strap_bcast_a: assert property ($rose(strap_done_r) |->
    bcast_addr_disable_o == $past(pin_s2[slp_pkg::STRAP_CLK])) else $error("bcast strap wrong");
  strap_iso_a: assert property ($rose(strap_done_r) |->
    isolate_o == $past(pin_s2[slp_pkg::STRAP_ER])) else $error("isolate strap wrong");
  strap_chain_a: assert property ($rose(strap_done_r) |->
    chain_test_n_o == $past(pin_s2[slp_pkg::STRAP_IRQ])) else $error("chain strap wrong");
  strap_hold_a: assert property (strap_done_r |=> $stable(straps_r))
    else $error("strap changed after latch");
  rx_drive_a: assert property (strap_done_r |=> rx_dv_oe_o && rx_er_oe_o &&
    rx_dv_o == $past(mii_rx_dv_i) && rx_clk_o == $past(mii_rx_clk_i))
    else $error("receive pins not driven");
  irq_clear_a: assert property (irq_read_s |=> st_r == '0)
    else $error("pending bits not cleared on read");
  irq_set_a: assert property (irq_events_i != '0 |=>
    (st_r & $past(irq_events_i)) == $past(irq_events_i)) else $error("event lost");
  irq_low_a: assert property (strap_done_r && !wake_opt2_sel_i && irq_act && !pol_high
    |=> irq_out_oe_o) else $error("active-low interrupt not pulled low");
  irq_high_a: assert property (strap_done_r && !wake_opt2_sel_i && !irq_act && pol_high
    |=> irq_out_oe_o) else $error("active-high idle not pulled low");
  wake_low_a: assert property (strap_done_r && wake_opt2_sel_i && wake_event_i
    |=> irq_out_oe_o) else $error("wake event not signalled");
  open_drain_a: assert property (irq_out_oe_o |-> !irq_out_o)
    else $error("interrupt pin driven high");

  sequence clear_race_s;
    rd_clr && irq_events_i != '0;
  endsequence
  sequence cs_write_s;
    wr_stb && reg_addr == slp_pkg::REG_IRQ_CS;
  endsequence
  sequence ctrl2_write_s;
    wr_stb && reg_addr == slp_pkg::REG_CTRL_TWO;
  endsequence

  // Straps are taken once, then frozen until the next reset
  strap_keep_a: assert property (strap_done_r |=> strap_done_r)
    else $error("strap latch reopened");
  rx_idle_a: assert property (!strap_done_r |-> !rx_dv_oe_o && !rx_clk_oe_o &&
    !rx_er_oe_o && !irq_out_oe_o)
    else $error("pin driven before straps latched");
  rx_follow_a: assert property (strap_done_r |=> rx_clk_oe_o &&
    rx_er_o == $past(mii_rx_er_i))
    else $error("receive error pin not driven");
  // Set wins: an event on the clearing read must stay pending for the next read
  irq_race_a: assert property (clear_race_s |=> st_r == $past(irq_events_i))
    else $error("event lost on clearing read");
  irq_enable_a: assert property (cs_write_s |=>
    en_r == $past(wr_data[slp_pkg::IRQ_EN_LSB +: slp_pkg::IRQ_W]))
    else $error("interrupt enables not written");
  unmapped_read_a: assert property (rd_stb && reg_addr != slp_pkg::REG_IRQ_CS &&
    reg_addr != slp_pkg::REG_CTRL_TWO |-> rd_data == '0)
    else $error("unmapped register not read as zero");
  pol_write_a: assert property (ctrl2_write_s |=> ctrl2_r == $past(wr_data))
    else $error("control-two not written");
  // Enable high means the pin is pulled low
  irq_quiet_a: assert property (strap_done_r && !wake_opt2_sel_i && !irq_act && !pol_high
    |=> !irq_out_oe_o)
    else $error("idle active-low interrupt pulls pin");
  irq_hi_act_a: assert property (strap_done_r && !wake_opt2_sel_i && irq_act && pol_high
    |=> !irq_out_oe_o)
    else $error("active-high interrupt not released");
  wake_idle_a: assert property (strap_done_r && wake_opt2_sel_i && !wake_event_i
    |=> !irq_out_oe_o)
    else $error("wake pin pulled without event");
  mgmt_drive_a: assert property (mdio_oe_o |-> !mdio_o)
    else $error("management data pin driven high");
  // One copy per pending bit: a bit only drops on a clearing read
  for (genvar b = 0; b < slp_pkg::IRQ_W; b++) begin : g_pend_hold
    pend_hold_a: assert property (st_r[b] && !rd_clr |=> st_r[b])
      else $error("pending bit dropped without read");
  end
endmodule // slp_strap_irq

/* File: testbench/slp_host_model.sv */
`timescale 1ns/10ps
module slp_host_model (
  input wire logic core_clk_i, // System clock
  input wire logic mdio_oe_i, // Device pulls data line low
  output logic mdc_o, // Management clock, still between frames
  output logic mdio_o // Resolved data line level
);
  logic drv_r = 1'b1;
  initial mdc_o = 1'b0;
  // Pull-up wins unless some party pulls low, so a released line never shows stale data
  assign mdio_o = drv_r & ~mdio_oe_i;
  task automatic half();
    repeat (8) @(negedge core_clk_i);
  endtask
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffff_ffff, 2'b01, op, phy, ra, 2'b10, wd};
    if (op == slp_pkg::OP_RD) f[17:0] = 18'h3_ffff;
    for (int i = 63; i >= 0; i--) begin
      drv_r = f[i];
      half();
      mdc_o = 1'b1;
      if (i < 16) rd[i] = mdio_o;
      half();
      mdc_o = 1'b0;
    end
    drv_r = 1'b1;
    half();
  endtask
endmodule // slp_host_model

/* File: testbench/slp_strap_irq_bench.sv */
`timescale 1ns/10ps
module slp_strap_irq_bench;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic mdc, mdio, mdio_oe, irq_oe, mdio_val, irq_val;
  logic wake_sel = 1'b0;
  logic wake_ev = 1'b0;
  logic [3:0] pull = 4'h0;
  logic [2:0] mii = 3'h0;
  logic [7:0] irq_ev = 8'h00;
  logic [15:0] rd;
  logic [31:0] seed = 32'h0000_0038;
  wire logic [2:0] rx, rx_oe;
  wire logic [3:0] strap;
  int miscompares = 0;
  int samples_checked = 0;
  slp_host_model slp_host_model_i (.core_clk_i(core_clk_i), .mdio_oe_i(mdio_oe & ~mdio_val),
    .mdc_o(mdc), .mdio_o(mdio));
  slp_strap_irq slp_strap_irq_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .mdc_i(mdc),
    .mdio_i(mdio), .mdio_o(mdio_val), .mdio_oe_o(mdio_oe),
    .rx_dv_pin_i(rx_oe[0] ? rx[0] : pull[0]), .rx_clk_pin_i(rx_oe[1] ? rx[1] : pull[1]),
    .rx_er_pin_i(rx_oe[2] ? rx[2] : pull[2]), .irq_out_pin_i(irq_oe ? irq_val : pull[3]),
    .mii_rx_dv_i(mii[0]), .mii_rx_clk_i(mii[1]), .mii_rx_er_i(mii[2]), .irq_events_i(irq_ev),
    .wake_opt2_sel_i(wake_sel), .wake_event_i(wake_ev), .rx_dv_o(rx[0]), .rx_dv_oe_o(rx_oe[0]),
    .rx_clk_o(rx[1]), .rx_clk_oe_o(rx_oe[1]), .rx_er_o(rx[2]), .rx_er_oe_o(rx_oe[2]),
    .irq_out_o(irq_val), .irq_out_oe_o(irq_oe), .cfg_strap_bit2_o(strap[slp_pkg::STRAP_DV]),
    .bcast_addr_disable_o(strap[slp_pkg::STRAP_CLK]), .isolate_o(strap[slp_pkg::STRAP_ER]),
    .chain_test_n_o(strap[slp_pkg::STRAP_IRQ]));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Pin pull-low enable: wake option follows the event, else polarity decides
  function automatic logic exp_pin(input logic sel, input logic wk, input logic pol,
                                   input logic act);
    return sel ? wk : (pol ? ~act : act);
  endfunction
  task automatic rnd();
    seed = xs(seed);
  endtask
  task automatic cmp1(input string what, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic cmp16(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    slp_host_model_i.xfer(slp_pkg::OP_WR, slp_pkg::PHY_ADDR_DEF, ra, wd, rd);
  endtask
  task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
    slp_host_model_i.xfer(slp_pkg::OP_RD, slp_pkg::PHY_ADDR_DEF, ra, 16'h0000, rd);
    cmp16("register", e, rd);
    cmp1("mdio drive value", 1'b0, mdio_val);
  endtask
  task automatic wait_pin(input logic e);
    int n;
    n = 0;
    while (irq_oe !== e && n < 8) begin
      @(negedge core_clk_i);
      n++;
    end
    cmp1("irq pin", e, irq_oe);
    cmp1("irq drive value", 1'b0, irq_val);
  endtask
  task automatic pulse(input logic [7:0] ev);
    irq_ev = ev;
    @(negedge core_clk_i);
    irq_ev = 8'h00;
    @(negedge core_clk_i);
  endtask
  task automatic do_reset(input logic [3:0] p);
    @(negedge core_clk_i);
    resetn_i = 1'b0;
    pull = p;
    repeat (16) @(negedge core_clk_i);
    cmp1("rx enables in reset", 1'b0, |rx_oe);
    resetn_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    for (int i = 0; i < 4; i++) cmp1("strap", p[i], strap[i]);
    cmp1("rx enables", 1'b1, &rx_oe);
    // Pins now carry data path values, which must not disturb the latched straps
    for (int n = 0; n < 20; n++) begin
      rnd();
      mii = seed[2:0];
      @(negedge core_clk_i);
      cmp16("rx outputs", {13'h0000, mii}, {13'h0000, rx});
      cmp16("held straps", {12'h000, p}, {12'h000, strap});
    end
  endtask
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #900_000;
    miscompares++;
    conclude();
  end
  initial begin
    logic [15:0] w;
    for (int r = 0; r < 4; r++) begin
      rnd();
      do_reset(r == 0 ? 4'h0 : (r == 1 ? 4'hf : seed[3:0]));
    end
    wait_pin(1'b0);
    wr(slp_pkg::REG_IRQ_CS, 16'h04ff);
    pulse(8'h20);
    wait_pin(1'b0);
    pulse(8'h04);
    wait_pin(exp_pin(1'b0, 1'b0, 1'b0, 1'b1));
    rdc(slp_pkg::REG_IRQ_CS, 16'h0424);
    wait_pin(1'b0);
    rdc(slp_pkg::REG_IRQ_CS, 16'h0400);
    for (int k = 0; k < 3; k++) begin
      rnd();
      w = (k == 0) ? 16'h0200 : seed[15:0];
      wr(slp_pkg::REG_CTRL_TWO, w);
      rdc(slp_pkg::REG_CTRL_TWO, w);
      wait_pin(exp_pin(1'b0, 1'b0, w[slp_pkg::CTRL2_IRQ_POL], 1'b0));
      pulse(8'h04);
      wait_pin(exp_pin(1'b0, 1'b0, w[slp_pkg::CTRL2_IRQ_POL], 1'b1));
      rdc(slp_pkg::REG_IRQ_CS, 16'h0404);
    end
    rdc(5'h10, 16'h0000);
    slp_host_model_i.xfer(slp_pkg::OP_RD, slp_pkg::PHY_ADDR_DEF ^ 5'h03, slp_pkg::REG_CTRL_TWO,
      16'h0000, rd);
    cmp16("foreign address", 16'hffff, rd);
    wake_sel = 1'b1;
    pulse(8'h04);
    wait_pin(1'b0);
    for (int k = 0; k < 8; k++) begin
      rnd();
      wake_ev = seed[0];
      @(negedge core_clk_i);
      wait_pin(exp_pin(1'b1, seed[0], w[slp_pkg::CTRL2_IRQ_POL], 1'b0));
    end
    conclude();
  end
endmodule // slp_strap_irq_bench
